// *** src/indicator_consts.svh ***
`ifndef INDICATOR_CONSTS_SVH
`define INDICATOR_CONSTS_SVH
// timing base
`define CLK_HZ 20000000
`define TICK_US 1000
// durations in milliseconds
`define BEEP_MS 10'd100
`define GAP_MS 10'd100
`define PAUSE_MS 10'd300
`define RAZZ_MS 10'd400
`define FLASH_MS 10'd100
`define BLINK_MS 10'd250
// tone codes on beep_tone
`define TONE_SILENT 3'h7
`define TONE_RAZZ 4'h8
`define TONE_HIGH 4'h9
`define TONE_LOW 4'ha
// request slots, lower index wins
`define NREQ 11
`define Q_ELEC 4'h0
`define Q_LASER 4'h1
`define Q_SCAN 4'h2
`define Q_MEM 4'h3
`define Q_UPG 4'h4
`define Q_CFG 4'h5
`define Q_INVAL 4'h6
`define Q_OCP 4'h7
`define Q_TMO 4'h8
`define Q_READ 4'h9
`define Q_PWR 4'ha
`endif

// *** src/indicator_pkg.sv ***
package indicator_pkg;
   // tone player states, one-hot
   typedef enum logic [5:0] {
      P_IDLE  = 6'h01,
      P_TONE  = 6'h02,
      P_GAP   = 6'h04,
      P_PAUSE = 6'h08,
      P_HIGH  = 6'h10,
      P_LOW   = 6'h20
   } player_e;
   typedef logic [3:0] tone_t; // beeper tone code
endpackage

// *** src/status_indicator.sv ***
`timescale 1ns/1ps
`include "indicator_consts.svh"
// Functional notes
// - eight tone settings, one silent
// - power-up: green on, red flash, one beep
// - power-up red lit during beep
// - good read: red flash, optional beep
// - upgrade needed: two beeps, alternate flashing
// - config entry: three beeps, LEDs flash
// - config exit: three beeps, flashing stops
// - comm timeout: three beeps when enabled
// - one-code done: three beeps, pause, high, low
// - yellow steady when gate button inactive
// - green follows laser in default mode
// - standby gate: dark until laser active
// - host not ready: red steady on
// - waiting host: red on, green off
// - invalid code in program mode: razzberry
// - laser fault: green flashes, one razzberry
// - scan fault: both flash, two razzberries
// - electronics fault: continuous razzberry, dark
// - config memory fault: three beeps
module status_indicator #(
   parameter int TICK_CYC = `CLK_HZ / 1000000 * `TICK_US // cycles per ms
) (
   input wire logic clk, // 20 MHz
   input wire logic reset_n, // sync, active low
   input wire logic [2:0] tone_sel, // 0 normal, 1..6 alternate, 7 silent
   input wire logic single_beep_en, // beep on good read
   input wire logic tmo_beep_en, // beep on comm timeout
   input wire logic yellow_fitted, // model with yellow led
   input wire logic selftest_done, // pulse, results below valid
   input wire logic elec_fault, // electronics self-test failed
   input wire logic mem_fault, // config_store_memory check failed
   input wire logic upgrade_needed, // firmware upgrade required
   input wire logic laser_fault, // laser subsystem fault level
   input wire logic scan_fault, // scan mechanism fault level
   input wire logic good_read, // pulse, decode succeeded
   input wire logic cfg_enter, // pulse, config mode entered
   input wire logic cfg_exit, // pulse, config mode left
   input wire logic comm_timeout, // pulse, host comms timeout
   input wire logic ocp_done, // pulse, one-code programming ok
   input wire logic invalid_code, // pulse, bad programming code
   input wire logic laser_active, // laser is on
   input wire logic gate_standby, // standby with gate enabled
   input wire logic gate_inactive, // gate button not active
   input wire logic host_not_ready, // message held for host
   input wire logic host_wait, // waiting for host comms
   output logic led_green, // green led
   output logic led_red, // red led
   output logic led_yellow, // yellow led
   output logic beep_on, // beeper sounding
   output indicator_pkg::tone_t beep_tone, // tone code
   output logic seq_busy // tone sequence in progress
);
   import indicator_pkg::*;

   localparam int TW = $clog2(TICK_CYC + 1);

   // pick lowest set request slot
   function automatic logic [3:0] pick(input logic [`NREQ-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = `NREQ - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // number of tones for a slot
   function automatic logic [2:0] tones_of(input logic [3:0] q);
      logic [2:0] n;
      n = 3'h1;
      if (q == `Q_SCAN || q == `Q_UPG) begin
         n = 3'h2;
      end else if (q == `Q_MEM || q == `Q_CFG || q == `Q_OCP || q == `Q_TMO) begin
         n = 3'h3;
      end
      return n;
   endfunction

   // slots using the razzberry tone
   function automatic logic is_razz(input logic [3:0] q);
      return q == `Q_ELEC || q == `Q_LASER || q == `Q_SCAN || q == `Q_INVAL;
   endfunction

   logic [TW-1:0] tick_ff, nxt_tick; // ms divider
   logic tick; // one-cycle ms enable
   logic [9:0] blink_ff, nxt_blink; // blink half-period
   logic phase_ff, nxt_phase; // blink phase
   logic [9:0] rfl_ff, nxt_rfl; // red flash timer
   logic ready_ff, nxt_ready; // self-test passed
   logic elec_ff, nxt_elec; // electronics fault latched
   logic upg_ff, nxt_upg; // upgrade mode
   logic cfg_ff, nxt_cfg; // configuration mode
   logic lflt_ff, nxt_lflt; // laser fault delayed
   logic sflt_ff, nxt_sflt; // scan fault delayed
   logic [`NREQ-1:0] pend_ff, nxt_pend; // pending tone requests
   logic [`NREQ-1:0] req_set, req_clr; // set and clear terms
   player_e st_ff, nxt_st; // player state
   logic [9:0] ms_ff, nxt_ms; // ms left in step
   logic [2:0] left_ff, nxt_left; // tones left
   logic [3:0] idx_ff, nxt_idx; // slot being played
   logic step_done; // current step expires
   logic audible; // selected tone not silent
   logic pwr_show, pwr_tone; // power-up phase, its beep
   logic g_ff, nxt_g, r_ff, nxt_r, y_ff, nxt_y; // led registers
   logic bon_ff, nxt_bon; // beeper enable register
   tone_t btn_ff, nxt_btn; // beeper tone register

   // timebase: ms tick and blink phase
   always_comb begin
      tick = tick_ff == TW'(TICK_CYC - 1);
      nxt_tick = tick ? '0 : tick_ff + TW'(1);
      nxt_blink = blink_ff;
      nxt_phase = phase_ff;
      nxt_rfl = rfl_ff;
      if (tick) begin
         nxt_blink = (blink_ff == `BLINK_MS - 10'd1) ? 10'h0 : blink_ff + 10'd1;
         nxt_phase = (blink_ff == `BLINK_MS - 10'd1) ? ~phase_ff : phase_ff;
         nxt_rfl = (rfl_ff != 10'h0) ? rfl_ff - 10'd1 : rfl_ff;
      end
      if (good_read) begin
         nxt_rfl = `FLASH_MS;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick_ff <= '0;
         blink_ff <= 10'h0;
         phase_ff <= 1'b0;
         rfl_ff <= 10'h0;
      end else begin
         tick_ff <= nxt_tick;
         blink_ff <= nxt_blink;
         phase_ff <= nxt_phase;
         rfl_ff <= nxt_rfl;
      end
   end

   // modes and request capture
   always_comb begin
      nxt_ready = ready_ff | (selftest_done & ~elec_fault);
      nxt_elec = elec_ff | (selftest_done & elec_fault);
      nxt_upg = upg_ff | (selftest_done & ~elec_fault & ~mem_fault & upgrade_needed);
      nxt_cfg = cfg_exit ? 1'b0 : (cfg_enter ? 1'b1 : cfg_ff);
      nxt_lflt = laser_fault;
      nxt_sflt = scan_fault;
      req_set = '0;
      req_set[`Q_ELEC] = selftest_done & elec_fault;
      req_set[`Q_LASER] = laser_fault & ~lflt_ff;
      req_set[`Q_SCAN] = scan_fault & ~sflt_ff;
      req_set[`Q_MEM] = selftest_done & ~elec_fault & mem_fault;
      req_set[`Q_UPG] = selftest_done & ~elec_fault & ~mem_fault & upgrade_needed;
      req_set[`Q_CFG] = cfg_enter | cfg_exit;
      req_set[`Q_INVAL] = invalid_code & (cfg_ff | upg_ff);
      req_set[`Q_OCP] = ocp_done;
      req_set[`Q_TMO] = comm_timeout & tmo_beep_en;
      req_set[`Q_READ] = good_read & single_beep_en;
      req_set[`Q_PWR] = selftest_done & ~elec_fault & ~mem_fault & ~upgrade_needed;
      req_clr = '0;
      if (st_ff == P_IDLE && pend_ff != '0) begin
         req_clr[pick(pend_ff)] = 1'b1;
      end
      // new request wins over clear
      nxt_pend = (pend_ff & ~req_clr) | req_set;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ready_ff <= 1'b0;
         elec_ff <= 1'b0;
         upg_ff <= 1'b0;
         cfg_ff <= 1'b0;
         lflt_ff <= 1'b0;
         sflt_ff <= 1'b0;
         pend_ff <= '0;
      end else begin
         ready_ff <= nxt_ready;
         elec_ff <= nxt_elec;
         upg_ff <= nxt_upg;
         cfg_ff <= nxt_cfg;
         lflt_ff <= nxt_lflt;
         sflt_ff <= nxt_sflt;
         pend_ff <= nxt_pend;
      end
   end

   // tone player
   always_comb begin
      nxt_st = st_ff;
      nxt_ms = ms_ff;
      nxt_left = left_ff;
      nxt_idx = idx_ff;
      step_done = tick && ms_ff == 10'd1;
      if (tick && ms_ff != 10'd1) begin
         nxt_ms = ms_ff - 10'd1;
      end
      unique case (st_ff)
         P_IDLE: begin
            if (pend_ff != '0) begin
               nxt_idx = pick(pend_ff);
               nxt_left = tones_of(nxt_idx);
               nxt_ms = is_razz(nxt_idx) ? `RAZZ_MS : `BEEP_MS;
               nxt_st = P_TONE;
            end
         end
         P_TONE: begin
            if (step_done) begin
               if (idx_ff == `Q_ELEC) begin
                  nxt_ms = `RAZZ_MS;
               end else if (left_ff > 3'h1) begin
                  nxt_left = left_ff - 3'h1;
                  nxt_ms = `GAP_MS;
                  nxt_st = P_GAP;
               end else if (idx_ff == `Q_OCP) begin
                  nxt_ms = `PAUSE_MS;
                  nxt_st = P_PAUSE;
               end else begin
                  nxt_st = P_IDLE;
               end
            end
         end
         P_GAP: begin
            if (step_done) begin
               nxt_ms = is_razz(idx_ff) ? `RAZZ_MS : `BEEP_MS;
               nxt_st = P_TONE;
            end
         end
         P_PAUSE: begin
            if (step_done) begin
               nxt_ms = `BEEP_MS;
               nxt_st = P_HIGH;
            end
         end
         P_HIGH: begin
            if (step_done) begin
               nxt_ms = `BEEP_MS;
               nxt_st = P_LOW;
            end
         end
         P_LOW: begin
            if (step_done) begin
               nxt_st = P_IDLE;
            end
         end
      endcase
      audible = tone_sel != `TONE_SILENT;
      nxt_bon = (nxt_st == P_TONE && (is_razz(nxt_idx) || audible))
         || ((nxt_st == P_HIGH || nxt_st == P_LOW) && audible);
      nxt_btn = (nxt_st == P_HIGH) ? `TONE_HIGH : (nxt_st == P_LOW) ? `TONE_LOW
         : is_razz(nxt_idx) ? `TONE_RAZZ : {1'b0, tone_sel};
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= P_IDLE;
         ms_ff <= 10'h1;
         left_ff <= 3'h0;
         idx_ff <= 4'h0;
         bon_ff <= 1'b0;
         btn_ff <= 4'h0;
      end else begin
         st_ff <= nxt_st;
         ms_ff <= nxt_ms;
         left_ff <= nxt_left;
         idx_ff <= nxt_idx;
         bon_ff <= nxt_bon;
         btn_ff <= nxt_btn;
      end
   end

   // led pattern selection
   always_comb begin
      pwr_show = pend_ff[`Q_PWR] || (idx_ff == `Q_PWR && st_ff != P_IDLE);
      pwr_tone = idx_ff == `Q_PWR && st_ff == P_TONE;
      nxt_g = laser_active;
      nxt_r = rfl_ff != 10'h0;
      // standby with gate enabled keeps yellow dark
      nxt_y = yellow_fitted & gate_inactive & ~gate_standby & ready_ff & ~elec_ff;
      if (elec_ff) begin
         nxt_g = 1'b0;
         nxt_r = 1'b0;
      end else if (laser_fault) begin
         nxt_g = phase_ff;
         nxt_r = 1'b0;
      end else if (scan_fault) begin
         nxt_g = phase_ff;
         nxt_r = phase_ff;
      end else if (upg_ff || cfg_ff) begin
         nxt_g = phase_ff;
         nxt_r = ~phase_ff;
      end else if (!ready_ff || pwr_show) begin
         nxt_g = 1'b1;
         nxt_r = pwr_tone;
      end else if (host_wait) begin
         nxt_g = 1'b0;
         nxt_r = 1'b1;
      end else if (host_not_ready) begin
         nxt_r = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         g_ff <= 1'b0;
         r_ff <= 1'b0;
         y_ff <= 1'b0;
      end else begin
         g_ff <= nxt_g;
         r_ff <= nxt_r;
         y_ff <= nxt_y;
      end
   end

   assign led_green = g_ff;
   assign led_red = r_ff;
   assign led_yellow = y_ff;
   assign beep_on = bon_ff;
   assign beep_tone = btn_ff;
   assign seq_busy = st_ff != P_IDLE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_last_tone;
      st_ff == P_TONE && idx_ff == `Q_OCP && left_ff == 3'h1 && step_done;
   endsequence
   sequence s_tail;
      st_ff == P_PAUSE ##1 (st_ff == P_PAUSE)[*1];
   endsequence

   a_silent_mute: assert property (st_ff == P_TONE && !is_razz(idx_ff)
      && tone_sel == `TONE_SILENT && $stable(tone_sel) |=> !beep_on)
      else $error("silent tone sounded");
   a_pwr_red_beep: assert property (pwr_tone && !elec_ff && !laser_fault
      && !scan_fault && !upg_ff && !cfg_ff |=> led_red && led_green)
      else $error("power-up red not lit during beep");
   a_read_queued: assert property (good_read && single_beep_en
      |=> pend_ff[`Q_READ] || (st_ff == P_TONE && idx_ff == `Q_READ))
      else $error("read beep lost");
   a_ocp_tail: assert property (s_last_tone |=> s_tail)
      else $error("one-code tail missing");
   a_yellow_gate: assert property (yellow_fitted && gate_inactive && ready_ff
      && !elec_ff |=> led_yellow)
      else $error("yellow not lit");
   a_host_wait: assert property (host_wait && ready_ff && !pwr_show && !elec_ff
      && !laser_fault && !scan_fault && !upg_ff && !cfg_ff |=> led_red && !led_green)
      else $error("waiting host pattern wrong");
   a_cfg_alt: assert property (cfg_ff && !elec_ff && !laser_fault
      && !scan_fault |=> led_red != led_green)
      else $error("config leds not alternating");
   a_elec_dark: assert property (elec_ff |=> !led_green && !led_red
      && !led_yellow)
      else $error("leds lit on electronics fault");
   a_seq_whole: assert property (st_ff != P_IDLE && !step_done
      |=> $stable(idx_ff))
      else $error("sequence interrupted");
   a_scan_two: assert property ($rose(st_ff == P_TONE) && $past(st_ff) == P_IDLE
      && idx_ff == `Q_SCAN |-> left_ff == 3'h2 && beep_tone == `TONE_RAZZ)
      else $error("scan fault tone count wrong");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "indicator_consts.svh"
module tb;
   import indicator_pkg::*;
   localparam int TK = 4; // cycles per ms in sim
   localparam int BEEP = 100 * TK; // beep length
   localparam int RAZZ = 400 * TK; // razzberry length
   localparam logic [12:0] L_ELEC = 13'h0001, L_MEM = 13'h0002, L_UPG = 13'h0004;
   localparam logic [12:0] L_LF = 13'h0008, L_SF = 13'h0010, L_LA = 13'h0020;
   localparam logic [12:0] L_GS = 13'h0040, L_GI = 13'h0080, L_HNR = 13'h0100;
   localparam logic [12:0] L_HW = 13'h0200, L_SB = 13'h0400, L_TMO = 13'h0800;
   localparam logic [12:0] L_YF = 13'h1000;
   localparam logic [6:0] E_ST = 7'h01, E_GR = 7'h02, E_CI = 7'h04, E_CO = 7'h08;
   localparam logic [6:0] E_TM = 7'h10, E_OC = 7'h20, E_IN = 7'h40;
   logic clk = 1'b0; // 50 ns clock
   logic reset_n = 1'b0; // sync reset
   logic [2:0] tone_sel = 3'h0; // tone choice
   logic [6:0] ev = 7'h00; // pulse inputs
   logic [12:0] lv = 13'h0000; // level inputs
   logic led_green, led_red, led_yellow, beep_on, seq_busy; // outputs
   tone_t beep_tone; // tone out
   int n_mismatch = 0; // mismatches
   int n_compared = 0; // comparisons
   tone_t tq[$]; // tones heard, one per beep start or tone change while sounding
   logic g_hi, g_lo, r_hi, both_hi, diff_hi, ended; // seen flags
   logic prev_beep = 1'b0; // beeper last cycle
   tone_t prev_tone = 4'h0; // tone code last cycle
   int run = 0; // current beep run
   int blen = 0; // last finished beep run
   int red_off = 0; // cycles red differs from beeper

   status_indicator #(.TICK_CYC(TK)) u_status_indicator (
      .clk(clk), .reset_n(reset_n), .tone_sel(tone_sel), .single_beep_en(lv[10]),
      .tmo_beep_en(lv[11]), .yellow_fitted(lv[12]), .selftest_done(ev[0]),
      .elec_fault(lv[0]), .mem_fault(lv[1]), .upgrade_needed(lv[2]), .laser_fault(lv[3]),
      .scan_fault(lv[4]), .good_read(ev[1]), .cfg_enter(ev[2]), .cfg_exit(ev[3]),
      .comm_timeout(ev[4]), .ocp_done(ev[5]), .invalid_code(ev[6]), .laser_active(lv[5]),
      .gate_standby(lv[6]), .gate_inactive(lv[7]), .host_not_ready(lv[8]),
      .host_wait(lv[9]), .led_green(led_green), .led_red(led_red),
      .led_yellow(led_yellow), .beep_on(beep_on), .beep_tone(beep_tone),
      .seq_busy(seq_busy)
   );

   // free running clock
   initial begin
      forever #25 clk = ~clk;
   end

   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // true when every heard tone is t
   function automatic bit all_is(input tone_t t);
      all_is = 1'b1;
      foreach (tq[i]) if (tq[i] !== t) all_is = 1'b0;
   endfunction

   task automatic clr();
      tq.delete();
      {g_hi, g_lo, r_hi, both_hi, diff_hi} = 5'h00;
      red_off = 0;
   endtask

   // one settled look at the outputs
   task automatic samp();
      @(negedge clk);
      // a new tone starts on a beep edge or a tone change while sounding
      if (beep_on === 1'b1 && (prev_beep !== 1'b1 || beep_tone !== prev_tone)) begin
         tq.push_back(beep_tone);
      end
      if (beep_on === 1'b1) begin
         run++;
      end else if (prev_beep === 1'b1) begin
         blen = run;
         run = 0;
      end
      prev_beep = beep_on;
      prev_tone = beep_tone;
      if (led_green === 1'b1) g_hi = 1'b1;
      if (led_green === 1'b0) g_lo = 1'b1;
      if (led_red === 1'b1) r_hi = 1'b1;
      if (led_green === 1'b1 && led_red === 1'b1) both_hi = 1'b1;
      if (led_green !== led_red) diff_hi = 1'b1;
      if (led_red !== beep_on) red_off++;
   endtask

   task automatic watch(input int n);
      repeat (n) samp();
   endtask

   // follow one tone sequence, bounded wait for start and end
   task automatic run_seq(input int maxc, input bit keep);
      int i;
      if (!keep) clr();
      i = 0;
      while (seq_busy !== 1'b1 && i < 20) begin
         samp();
         i++;
      end
      i = 0;
      while (seq_busy === 1'b1 && i < maxc) begin
         samp();
         i++;
      end
      ended = (seq_busy !== 1'b1);
      samp();
   endtask

   task automatic pulse(input logic [6:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 7'h00;
   endtask

   task automatic setlv(input logic [12:0] s, input logic [12:0] c);
      @(posedge clk);
      lv <= (lv & ~c) | s;
      repeat (3) @(negedge clk);
   endtask

   // reset, watch the not-ready state, then report self-test
   task automatic boot(input logic [12:0] faults);
      @(posedge clk);
      reset_n <= 1'b0;
      lv <= faults;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({led_green, led_red, led_yellow, beep_on}, 16'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      clr();
      watch(3);
      pulse(E_ST);
   endtask

   task automatic t_power();
      boot(13'h0000);
      chk(16'(g_hi), 16'h1);
      run_seq(1200, 1'b0);
      chk(16'(tq.size()), 16'h1);
      chk(16'(all_is(4'h0) && g_hi), 16'h1);
      chk(16'(red_off <= 2 && r_hi), 16'h1);
      chk(16'(blen >= BEEP - TK && blen <= BEEP), 16'h1);
      $display("test power done");
   endtask

   task automatic t_read();
      setlv(L_SB, 13'h0);
      for (int t = 0; t < 8; t++) begin
         @(posedge clk);
         tone_sel <= 3'(t);
         pulse(E_GR);
         run_seq(1200, 1'b0);
         chk(16'(tq.size()), 16'(t < 7));
         chk(16'(all_is(4'(t)) && r_hi), 16'h1);
         chk(16'(t == 7 || (blen >= BEEP - TK && blen <= BEEP)), 16'h1);
      end
      @(posedge clk);
      tone_sel <= 3'h0;
      setlv(13'h0, L_SB);
      pulse(E_GR);
      clr();
      watch(600);
      chk({15'(tq.size()), r_hi}, 16'h1);
      setlv(L_LA, 13'h0);
      chk(led_green, 16'h1);
      setlv(13'h0, L_LA);
      chk(led_green, 16'h0);
      $display("test read done");
   endtask

   task automatic t_leds();
      setlv(L_HW | L_LA, 13'h0);
      chk({led_red, led_green}, 16'h2);
      setlv(L_HNR, L_HW);
      chk({led_red, led_green}, 16'h3);
      setlv(13'h0, L_LA);
      chk({led_red, led_green}, 16'h2);
      setlv(L_GS, L_HNR);
      chk({led_red, led_green, led_yellow}, 16'h0);
      setlv(L_LA, 13'h0);
      chk(led_green, 16'h1);
      setlv(L_YF | L_GI, L_LA | L_GS);
      chk(led_yellow, 16'h1);
      setlv(13'h0, L_YF);
      chk(led_yellow, 16'h0);
      setlv(13'h0, L_GI);
      $display("test leds done");
   endtask

   task automatic t_tmo();
      pulse(E_TM);
      clr();
      watch(600);
      chk(16'(tq.size()), 16'h0);
      setlv(L_TMO, 13'h0);
      pulse(E_TM);
      run_seq(3000, 1'b0);
      chk(16'(tq.size()), 16'h3);
      setlv(13'h0, L_TMO);
      $display("test timeout done");
   endtask

   task automatic t_faults();
      setlv(L_LF, 13'h0);
      run_seq(2000, 1'b0);
      chk(16'(tq.size()), 16'h1);
      chk(16'(all_is(`TONE_RAZZ) && blen >= RAZZ - TK && blen <= RAZZ), 16'h1);
      clr();
      watch(2500);
      chk({g_hi, g_lo, r_hi}, 16'h6);
      setlv(L_SF, L_LF);
      run_seq(4000, 1'b0);
      chk(16'(tq.size()), 16'h2);
      chk(16'(all_is(`TONE_RAZZ)), 16'h1);
      clr();
      watch(2500);
      chk({both_hi, g_lo, diff_hi}, 16'h6);
      setlv(13'h0, L_SF);
      $display("test faults done");
   endtask

   task automatic t_cfg();
      pulse(E_CI);
      run_seq(3000, 1'b0);
      chk({15'(tq.size()), r_hi}, 16'h7);
      clr();
      watch(2500);
      chk({g_hi, r_hi, both_hi, diff_hi}, 16'hd);
      pulse(E_IN | E_OC);
      run_seq(2000, 1'b0);
      run_seq(6000, 1'b1);
      chk(16'(tq.size() > 0 && tq[0] === `TONE_RAZZ), 16'h1);
      chk(16'(tq.size()), 16'h6);
      if (tq.size() == 6) begin
         chk({tq[0], tq[3], tq[4], tq[5]}, 16'h809a);
         chk({tq[1], tq[2]}, 16'h0);
      end
      pulse(E_CO);
      run_seq(3000, 1'b0);
      chk({15'(tq.size()), ended}, 16'h7);
      clr();
      watch(1500);
      chk({g_hi, r_hi}, 16'h0);
      $display("test config done");
   endtask

   task automatic t_boot();
      boot(L_MEM);
      run_seq(3000, 1'b0);
      chk(16'(tq.size()), 16'h3);
      boot(L_UPG);
      run_seq(3000, 1'b0);
      chk(16'(tq.size()), 16'h2);
      clr();
      watch(2500);
      chk({g_hi, r_hi, both_hi}, 16'h6);
      boot(L_ELEC);
      run_seq(3000, 1'b0);
      chk({15'(tq.size()), ended}, 16'h2);
      chk(16'(all_is(`TONE_RAZZ)), 16'h1);
      clr();
      watch(20);
      chk({beep_on, g_hi, r_hi, led_yellow}, 16'h8);
      $display("test boot faults done");
   endtask

   // main sequence
   initial begin
      t_power();
      t_read();
      t_leds();
      t_tmo();
      t_faults();
      t_cfg();
      t_boot();
      stop_test();
   end

   // watchdog, well past the expected run length
   initial begin
      #4000000;
      n_mismatch++;
      stop_test();
   end
endmodule
